// >>> sim/mdio_host_props.sv
`timescale 1ns/1ns

// ****************************************************************
// Port checks on the management host
// ****************************************************************
module mdio_host_props #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              regRead,
  input wire logic [31:0]       regRdata,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Handshake steps of the device bus
  sequence wAccept;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rAccept;
    rvalid && rready;
  endsequence

  chk_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 32'h0) else $error("read data outside its cycle");
  chk_wstrb_full: assert property (
    awvalid |-> wstrb == 4'hF) else $error("partial write strobe");
  chk_aw_stable: assert property (
    awvalid && !awready |=> awvalid && $stable(awaddr) && $stable(wdata))
    else $error("write request changed while waiting");
  chk_ar_stable: assert property (
    arvalid && !arready |=> arvalid && $stable(araddr)) else $error("read request changed");
  chk_aw_w_pair: assert property (
    $rose(awvalid) |-> $rose(wvalid)) else $error("address and data not raised together");
  chk_single_txn: assert property (
    !(awvalid && arvalid)) else $error("two accesses outstanding");
  chk_w_resp: assert property (
    wAccept |=> bready && !awvalid && !wvalid) else $error("write response not awaited");
  chk_b_release: assert property (
    bvalid && bready |=> !bready && !awvalid && !arvalid) else $error("write response held");
  chk_r_hold: assert property (
    rready && !rvalid |=> rready) else $error("read ready dropped early");
  chk_r_release: assert property (
    rAccept |=> !rready ##1 !arvalid && !awvalid) else $error("next access too soon");
endmodule

bind mdio_management_host mdio_host_props #(.ADDR_W(ADDR_W)) props_i (
  .clk(clk), .reset_n(reset_n), .regRead(regRead), .regRdata(regRdata),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

// >>> sim/mgmt_dev_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Behavioural management device with a PHY behind it
// ****************************************************************
module mgmt_dev_model
  import mdio_host_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [7:0]        busyLen,
  input  wire logic              errOn
);
  logic [5:0]  div;
  logic        en;
  logic [4:0]  prt;
  logic [4:0]  dev;
  logic [1:0]  op;
  logic [15:0] txd;
  logic [15:0] rxd;
  logic [15:0] cur;
  logic [7:0]  busy;
  logic        ph;
  logic        ready;
  logic [31:0] lastCfg1;
  logic [31:0] rdVal;
  logic [15:0] mem [0:255];

  // Accepts only on alternate cycles, so requests sometimes wait
  assign ready   = (busy == 8'h00);
  assign awready = awvalid && wvalid && !bvalid && ph;
  assign wready  = awready;
  assign arready = arvalid && !rvalid && ph;
  assign rresp   = 2'h0;

  // Register read view
  always_comb begin
    case (16'(araddr))
      DEV_CFG0:   rdVal = {25'h0, en, div};
      DEV_CFG1:   rdVal = {3'h0, prt, 3'h0, dev, op, 2'h0, !ready, 3'h0, ready, 7'h0};
      DEV_TXDATA: rdVal = {16'h0, txd};
      DEV_RXDATA: rdVal = {16'h0, rxd};
      default:    rdVal = 32'h0;
    endcase
  end

  // Bus answers, frame effects and the busy window
  always @(posedge clk) begin
    if (!reset_n) begin
      {div, en, busy, ph, bvalid, rvalid, bresp, rdata} <= '0;
    end else begin
      ph <= !ph;
      if (busy != 8'h00) busy <= busy - 8'h01;
      if (bvalid && bready) bvalid <= 1'b0;
      if (rvalid && rready) rvalid <= 1'b0;
      else if (!rvalid) rdata <= ~rdata; // Released data lines keep changing
      if (rready && !rvalid && !ph) begin // Answers a cycle after acceptance
        rvalid <= 1'b1;
        rdata <= rdVal;
      end
      if (awready) begin
        bvalid <= 1'b1;
        bresp <= errOn ? 2'h2 : 2'h0;
        case (16'(awaddr))
          DEV_CFG0: begin
            div <= wdata[5:0];
            en <= wdata[6] && (wdata[5:0] != 6'h00);
          end
          DEV_TXDATA: txd <= wdata[15:0];
          DEV_CFG1: begin
            {prt, dev, op} <= {wdata[28:24], wdata[20:16], wdata[15:14]};
            lastCfg1 <= wdata;
            if (wdata[11] && en && ready) begin
              busy <= busyLen;
              case (wdata[15:14])
                2'h0: cur <= txd;
                2'h1: mem[cur[7:0]] <= txd;
                2'h3: rxd <= mem[cur[7:0]];
                default: begin
                  rxd <= mem[cur[7:0]];
                  cur <= cur + 16'h1;
                end
              endcase
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns

module tb
  import mdio_host_pkg::*;
;
  logic clk, reset_n, regWrite, regRead, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, errOn;
  logic [7:0]  regAddr, busyLen;
  logic [31:0] regWdata, regRdata, wdata, rdata;
  logic [15:0] awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          nErrors, numChecks;

  mdio_management_host mdio_management_host_i (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  mgmt_dev_model mgmt_dev_model_i (.clk(clk), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .busyLen(busyLen), .errOn(errOn));

  // ****************************************************************
  // Clock, tasks and closing
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask
  // Polls the busy flag; the watchdog catches a job that never ends
  task automatic job(input logic [1:0] j);
    logic [31:0] v;
    wr(HOST_GO, {30'h0, j});
    v = 32'h1;
    while (v[0] !== 1'b0) rd(HOST_STATUS, v);
  endtask
  task automatic irqChk(input logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(50 * 30000);
    nErrors++;
    tally_and_finish;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {reset_n, regWrite, regRead, errOn, regAddr, regWdata} = '0;
    busyLen = 8'h14;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdChk("cfg", HOST_CFG, 32'h0);
    rdChk("status", HOST_STATUS, 32'h0);
    rdChk("mask", HOST_IRQ_MASK, 32'h0);
    rdChk("unmapped", 8'h24, 32'h0);
    job(JOB_READ);
    rdChk("irqStat", HOST_IRQ_STAT, 32'h2);
    irqChk(1'b0);
    wr(HOST_IRQ_MASK, 32'h3);
    irqChk(1'b1);
    wr(HOST_IRQ_STAT, 32'h2);
    irqChk(1'b0);
    wr(HOST_CFG, 32'h40);
    job(JOB_SETADDR);
    rdChk("cfgZero", HOST_CFG, 32'h0);
    chk("devEn", {31'h0, mgmt_dev_model_i.en}, 32'h0);
    wr(HOST_CFG, 32'h41);
    job(JOB_SETADDR);
    rdChk("cfgRaised", HOST_CFG, 32'h43);
    chk("devCfg0", {25'h0, mgmt_dev_model_i.en, mgmt_dev_model_i.div}, 32'h43);
    rdChk("cfgOk", HOST_STATUS, 32'h2);
    wr(HOST_IRQ_STAT, 32'h3);
    wr(HOST_TARGET, 32'h300);
    wr(HOST_REGADDR, 32'h2A);
    wr(HOST_WDATA, 32'h30);
    job(JOB_WRITE);
    chk("phyWord", {16'h0, mgmt_dev_model_i.mem[8'h2A]}, 32'h30);
    chk("wrCfg1", mgmt_dev_model_i.lastCfg1, 32'h00034800);
    rdChk("doneBit", HOST_IRQ_STAT, 32'h1);
    mgmt_dev_model_i.mem[1] = 16'h0006;
    busyLen <= 8'hC8;
    wr(HOST_REGADDR, 32'h1);
    wr(HOST_GO, {30'h0, JOB_READ});
    wr(HOST_CFG, 32'h45);
    job(JOB_SETADDR);
    rdChk("cfgKept", HOST_CFG, 32'h43);
    job(JOB_READ);
    rdChk("rdata", HOST_RDATA, 32'h6);
    chk("rdCfg1", mgmt_dev_model_i.lastCfg1, 32'h0003C800);
    busyLen <= 8'h14;
    for (int i = 0; i < 3; i++) mgmt_dev_model_i.mem[8'h10 + i] = 16'hA50 + 16'(i);
    wr(HOST_TARGET, 32'h105);
    wr(HOST_REGADDR, 32'h10);
    job(JOB_SETADDR);
    chk("curAddr", {16'h0, mgmt_dev_model_i.cur}, 32'h10);
    for (int i = 0; i < 3; i++) begin
      job(JOB_INCR);
      rdChk("incrData", HOST_RDATA, 32'hA50 + 32'(i));
    end
    chk("curNext", {16'h0, mgmt_dev_model_i.cur}, 32'h13);
    chk("incCfg1", mgmt_dev_model_i.lastCfg1, 32'h05018800);
    wr(HOST_IRQ_STAT, 32'h3);
    errOn <= 1'b1;
    job(JOB_SETADDR);
    errOn <= 1'b0;
    rdChk("errBit", HOST_IRQ_STAT, 32'h2);
    rdChk("idle", HOST_STATUS, 32'h2);
    irqChk(1'b1);
    tally_and_finish;
  end
endmodule

// >>> verilog/axi_lite_single_master.sv
`timescale 1ns/1ns

// ****************************************************************
// One-at-a-time AXI4-Lite master
// ****************************************************************
module axi_lite_single_master
  import mdio_host_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              cmdValid,
  input  wire logic              cmdWrite,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [31:0]       cmdWdata,
  output logic                   cmdDone,
  output logic                   cmdErr,
  output logic [31:0]            cmdRdata,
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [31:0]            wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);

  typedef struct packed {
    axi_state_type     state;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
    logic              done;
    logic              err;
    logic [31:0]       rdata;
  } axi_regs_type;

  axi_regs_type q;
  axi_regs_type d;

  // Handshake sequencing for one write or one read
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.state)
      AXI_IDLE: begin
        if (cmdValid && cmdWrite) begin
          d.awaddr  = cmdAddr;
          d.wdata   = cmdWdata;
          d.awvalid = 1'b1;
          d.wvalid  = 1'b1;
          d.state   = AXI_WRITE;
        end else if (cmdValid) begin
          d.araddr  = cmdAddr;
          d.arvalid = 1'b1;
          d.state   = AXI_READ;
        end
      end
      AXI_WRITE: begin
        if (awready) begin
          d.awvalid = 1'b0;
        end
        if (wready) begin
          d.wvalid = 1'b0;
        end
        if ((!q.awvalid || awready) && (!q.wvalid || wready)) begin
          d.bready = 1'b1;
          d.state  = AXI_RESP_B;
        end
      end
      AXI_RESP_B: begin
        if (bvalid) begin
          d.bready = 1'b0;
          d.done   = 1'b1;
          d.err    = bresp[1];
          d.state  = AXI_IDLE;
        end
      end
      AXI_READ: begin
        if (arready) begin
          d.arvalid = 1'b0;
          d.rready  = 1'b1;
          d.state   = AXI_RESP_R;
        end
      end
      AXI_RESP_R: begin
        if (rvalid) begin
          d.rready = 1'b0;
          d.rdata  = rdata;
          d.err    = rresp[1];
          d.done   = 1'b1;
          d.state  = AXI_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops, except wstrb, which is tied to 4'hF
  assign cmdDone  = q.done;
  assign cmdErr   = q.err;
  assign cmdRdata = q.rdata;
  assign awaddr   = q.awaddr;
  assign awvalid  = q.awvalid;
  assign wdata    = q.wdata;
  assign wstrb    = 4'hF;
  assign wvalid   = q.wvalid;
  assign bready   = q.bready;
  assign araddr   = q.araddr;
  assign arvalid  = q.arvalid;
  assign rready   = q.rready;

endmodule

// >>> verilog/mdio_host_pkg.sv
package mdio_host_pkg;

  // ****************************************************************
  // Host-side register map (plain port, byte addresses)
  // ****************************************************************
  localparam logic [7:0] HOST_CFG      = 8'h00;
  localparam logic [7:0] HOST_TARGET   = 8'h04;
  localparam logic [7:0] HOST_REGADDR  = 8'h08;
  localparam logic [7:0] HOST_WDATA    = 8'h0C;
  localparam logic [7:0] HOST_GO       = 8'h10;
  localparam logic [7:0] HOST_STATUS   = 8'h14;
  localparam logic [7:0] HOST_RDATA    = 8'h18;
  localparam logic [7:0] HOST_IRQ_STAT = 8'h1C;
  localparam logic [7:0] HOST_IRQ_MASK = 8'h20;

  // ****************************************************************
  // Device register offsets on the management bus
  // ****************************************************************
  localparam logic [15:0] DEV_CFG0   = 16'h0500;
  localparam logic [15:0] DEV_CFG1   = 16'h0504;
  localparam logic [15:0] DEV_TXDATA = 16'h0508;
  localparam logic [15:0] DEV_RXDATA = 16'h050C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG0_DIV_LSB   = 0;
  localparam int CFG0_EN_BIT    = 6;
  localparam int CFG1_OP_LSB    = 14;
  localparam int CFG1_INIT_BIT  = 11;
  localparam int CFG1_READY_BIT = 7;
  localparam int CFG1_DEVAD_LSB = 16;
  localparam int CFG1_PRTAD_LSB = 24;
  localparam int GO_JOB_LSB     = 0;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ERR_BIT    = 1;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [5:0]  DIV_RESET   = 6'h00;
  localparam logic [1:0]  MASK_RESET  = 2'h0;
  localparam int          CLK_KHZ     = 20000;
  localparam int          MDC_MAX_KHZ = 2500;
  // Least divide value keeping the serial clock at or below its maximum
  localparam int          DIV_MIN_INT = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ) - 1;
  localparam logic [5:0]  DIV_MIN     = 6'(DIV_MIN_INT);

  // ****************************************************************
  // Frame opcodes and host jobs
  // ****************************************************************
  localparam logic [1:0] OP_ADDR  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_INCR  = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;

  localparam logic [1:0] JOB_WRITE   = 2'h0;
  localparam logic [1:0] JOB_READ    = 2'h1;
  localparam logic [1:0] JOB_SETADDR = 2'h2;
  localparam logic [1:0] JOB_INCR    = 2'h3;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CFG0, SEQ_PRE_POLL, SEQ_TXD, SEQ_INIT, SEQ_POST_POLL, SEQ_RXD
  } seq_state_type;

  typedef enum logic [2:0] {
    AXI_IDLE, AXI_WRITE, AXI_RESP_B, AXI_READ, AXI_RESP_R
  } axi_state_type;

endpackage

// >>> verilog/mdio_management_host.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns

// Summary of operation
// - Nonzero divide values below the 2.5 MHz limit are raised to the least safe value; zero is kept and clears enable.
// - Configuration word 0 is written with divide and enable before any frame.
// - A frame starts only after ready reads 1, by writing the initiate bit.
// - Opcode 00 sends the PHY register address from the transmit data.
// - Opcode 01 writes the transmit data word at the current address.
// - Opcode 11 reads the word at the current address.
// - Opcode 10 reads the word and then advances the PHY address.
// - Repeated increment jobs read consecutive PHY registers after one address.
// - Port and device address fields of word 1 select the target.
// - A register write is an address frame then a write frame.
// - A register read is an address frame, read frame, then receive data fetch.
module mdio_management_host
  import mdio_host_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [31:0]            regRdata,
  output logic                   irq,
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [31:0]            wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    seq_state_type     state;
    logic [1:0]        job;
    logic [1:0]        opcode;
    logic [5:0]        div;
    logic              en;
    logic              cfgOk;
    logic [4:0]        prtad;
    logic [4:0]        devad;
    logic [15:0]       phyAddr;
    logic [15:0]       phyWdata;
    logic [15:0]       phyRdata;
    logic [1:0]        irqStat;
    logic [1:0]        irqMask;
    logic              irq;
    logic [31:0]       rdOut;
    logic              cmdValid;
    logic              cmdWrite;
    logic [ADDR_W-1:0] cmdAddr;
    logic [31:0]       cmdWdata;
  } host_regs_type;

  host_regs_type q;
  host_regs_type d;

  logic        cmdDone;
  logic        cmdErr;
  logic [31:0] cmdRdata;

  // Frame control word for the current opcode with initiate set
  function automatic logic [31:0] frameWord(input logic [1:0] op, input logic [4:0] prt,
                                            input logic [4:0] dev);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[CFG1_OP_LSB +: 2]            = op;
    w[CFG1_DEVAD_LSB +: 5]         = dev;
    w[CFG1_PRTAD_LSB +: 5]         = prt;
    w[CFG1_INIT_BIT]               = 1'b1;
    return w;
  endfunction

  // Queue one bus access for the master
  function automatic host_regs_type issue(input host_regs_type s, input logic wr,
                                          input logic [15:0] a, input logic [31:0] v);
    host_regs_type r;
    r          = s;
    r.cmdValid = 1'b1;
    r.cmdWrite = wr;
    r.cmdAddr  = ADDR_W'(a);
    r.cmdWdata = v;
    return r;
  endfunction

  // ****************************************************************
  // Sequencer and host registers
  // ****************************************************************
  always_comb begin
    logic       setDone;
    logic       setErr;
    logic [1:0] clrBits;
    logic [5:0] newDiv;
    setDone    = 1'b0;
    setErr     = 1'b0;
    clrBits    = 2'h0;
    newDiv     = regWdata[CFG0_DIV_LSB +: 6];
    d          = q;
    d.cmdValid = 1'b0;
    d.rdOut    = 32'h0000_0000;

    // Host register writes; configuration and jobs only while idle
    if (regWrite) begin
      unique case (regAddr)
        HOST_CFG: begin
          if (q.state == SEQ_IDLE) begin
            if (newDiv != DIV_RESET && newDiv < DIV_MIN) begin
              newDiv = DIV_MIN;
            end
            d.div   = newDiv;
            d.en    = regWdata[CFG0_EN_BIT] && (newDiv != DIV_RESET);
            d.cfgOk = 1'b0;
            d       = issue(d, 1'b1, DEV_CFG0,
                            {25'h0, d.en, d.div});
            d.state = SEQ_CFG0;
          end
        end
        HOST_TARGET: begin
          d.prtad = regWdata[4:0];
          d.devad = regWdata[12:8];
        end
        HOST_REGADDR: d.phyAddr  = regWdata[15:0];
        HOST_WDATA:   d.phyWdata = regWdata[15:0];
        HOST_GO: begin
          if (q.state == SEQ_IDLE) begin
            if (!q.cfgOk) begin
              setErr = 1'b1;
            end else begin
              d.job    = regWdata[GO_JOB_LSB +: 2];
              d.opcode = (d.job == JOB_INCR) ? OP_INCR : OP_ADDR;
              d        = issue(d, 1'b0, DEV_CFG1, 32'h0000_0000);
              d.state  = SEQ_PRE_POLL;
            end
          end
        end
        HOST_IRQ_STAT: clrBits   = regWdata[1:0];
        HOST_IRQ_MASK: d.irqMask = regWdata[1:0];
        default: ;
      endcase
    end

    // Host register reads, data one cycle later
    if (regRead) begin
      unique case (regAddr)
        HOST_CFG:      d.rdOut = {25'h0, q.en, q.div};
        HOST_TARGET:   d.rdOut = {19'h0, q.devad, 3'h0, q.prtad};
        HOST_REGADDR:  d.rdOut = {16'h0, q.phyAddr};
        HOST_WDATA:    d.rdOut = {16'h0, q.phyWdata};
        HOST_STATUS:   d.rdOut = {30'h0, q.cfgOk, q.state != SEQ_IDLE};
        HOST_RDATA:    d.rdOut = {16'h0, q.phyRdata};
        HOST_IRQ_STAT: d.rdOut = {30'h0, q.irqStat};
        HOST_IRQ_MASK: d.rdOut = {30'h0, q.irqMask};
        default:       d.rdOut = 32'h0000_0000;
      endcase
    end

    // Device access sequencing, advanced by each completed bus access
    if (cmdDone && cmdErr) begin
      setErr  = 1'b1;
      d.state = SEQ_IDLE;
    end else if (cmdDone) begin
      unique case (q.state)
        SEQ_CFG0: begin
          d.cfgOk = q.en;
          setDone = 1'b1;
          d.state = SEQ_IDLE;
        end
        SEQ_PRE_POLL: begin
          if (!cmdRdata[CFG1_READY_BIT]) begin
            d = issue(d, 1'b0, DEV_CFG1, 32'h0000_0000);
          end else if (q.opcode == OP_ADDR) begin
            d       = issue(d, 1'b1, DEV_TXDATA, {16'h0, q.phyAddr});
            d.state = SEQ_TXD;
          end else begin
            d       = issue(d, 1'b1, DEV_CFG1, frameWord(q.opcode, q.prtad, q.devad));
            d.state = SEQ_INIT;
          end
        end
        SEQ_TXD: begin
          d       = issue(d, 1'b1, DEV_CFG1, frameWord(q.opcode, q.prtad, q.devad));
          d.state = SEQ_INIT;
        end
        SEQ_INIT: begin
          d       = issue(d, 1'b0, DEV_CFG1, 32'h0000_0000);
          d.state = SEQ_POST_POLL;
        end
        SEQ_POST_POLL: begin
          if (!cmdRdata[CFG1_READY_BIT] || cmdRdata[CFG1_INIT_BIT]) begin
            d = issue(d, 1'b0, DEV_CFG1, 32'h0000_0000);
          end else if (q.opcode == OP_READ || q.opcode == OP_INCR) begin
            d       = issue(d, 1'b0, DEV_RXDATA, 32'h0000_0000);
            d.state = SEQ_RXD;
          end else if (q.opcode == OP_ADDR && q.job == JOB_WRITE) begin
            d.opcode = OP_WRITE;
            d        = issue(d, 1'b1, DEV_TXDATA, {16'h0, q.phyWdata});
            d.state  = SEQ_TXD;
          end else if (q.opcode == OP_ADDR && q.job == JOB_READ) begin
            d.opcode = OP_READ;
            d        = issue(d, 1'b1, DEV_CFG1,
                             frameWord(OP_READ, q.prtad, q.devad));
            d.state  = SEQ_INIT;
          end else begin
            setDone = 1'b1;
            d.state = SEQ_IDLE;
          end
        end
        SEQ_RXD: begin
          d.phyRdata = cmdRdata[15:0];
          setDone    = 1'b1;
          d.state    = SEQ_IDLE;
        end
        SEQ_IDLE: ;
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle
    d.irqStat = (q.irqStat & ~clrBits) | {setErr, setDone};
    d.irq     = |(d.irqStat & d.irqMask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q         <= '0;
      q.state   <= SEQ_IDLE;
      q.div     <= DIV_RESET;
      q.irqMask <= MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdOut;
  assign irq      = q.irq;

  // ****************************************************************
  // Bus master towards the device
  // ****************************************************************
  axi_lite_single_master #(
    .ADDR_W (ADDR_W)
  ) busMaster (
    .clk      (clk),
    .reset_n  (reset_n),
    .cmdValid (q.cmdValid),
    .cmdWrite (q.cmdWrite),
    .cmdAddr  (q.cmdAddr),
    .cmdWdata (q.cmdWdata),
    .cmdDone  (cmdDone),
    .cmdErr   (cmdErr),
    .cmdRdata (cmdRdata),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready)
  );

endmodule
